// ### src/upf_pkg.sv
// Constants and carrier types for the parallel FIFO port
// Operation
// - Drive receive byte while read strobe low
// - Read strobe rise: release bus, advance
// - Write strobe fall: sample byte, append
// - Flush transmit data within timeout
// - Timeout programmable 1 to 255 ms
// - Space flag low: write strobe accepted
// - Flags float during reset
// - Receive flag low while byte waits
// - Receive flag high once buffer empty
// - Wake option in suspend: receive pin input
// - Power enable low configured, high suspended
package upf_pkg;
	// ----------------------------------------
	// Sizes and timing
	// ----------------------------------------
	localparam int RX_DEPTH = 256;
	localparam int TX_DEPTH = 128;
	localparam int CLK_HZ = 20000000;
	localparam int MS_CYCLES = CLK_HZ / 1000;
	localparam logic [7:0] FLUSH_MS_RST = 8'h10;
	localparam logic [7:0] FLUSH_MS_MIN = 8'h01;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} upf_byte_t;

	typedef struct packed {
		logic [7:0] out;
		logic oe;
	} upf_bus_t;
endpackage

// ### src/upf_fifo.sv
// Byte FIFO with valid/ready on both sides
`timescale 1ns/1ps
module upf_fifo #(
	parameter int DEPTH = 256
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire upf_pkg::upf_byte_t i_wr,
	output logic o_wr_ready,
	output upf_pkg::upf_byte_t o_rd,
	input wire logic i_rd_ready,
	output logic [$clog2(DEPTH):0] o_count
);
	localparam int AW = $clog2(DEPTH);
	logic [7:0] mem [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	// ----------------------------------------
	// Pointers
	// ----------------------------------------
	always_comb begin
		push = i_wr.valid && (cnt_q != (AW+1)'(DEPTH));
		pop = i_rd_ready && (cnt_q != '0);
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	// No reset on storage; the count guards stale words
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wp_q] <= i_wr.data;
		end
	end

	assign o_wr_ready = cnt_q != (AW+1)'(DEPTH);
	assign o_rd.valid = cnt_q != '0;
	assign o_rd.data = mem[rp_q];
	assign o_count = cnt_q;
endmodule // upf_fifo

// ### src/upf_port.sv
// Parallel FIFO host port top
`timescale 1ns/1ps
module upf_port (
	input wire logic I_CLK,
	input wire logic I_RST_B,
	input wire logic I_READ_STROBE_N,
	input wire logic I_WRITE_STROBE,
	input wire logic [7:0] I_DATA,
	output logic [7:0] O_DATA,
	output logic O_DATA_OE,
	output logic O_RX_AVAIL_N,
	output logic O_RX_AVAIL_N_OE,
	input wire logic I_RX_AVAIL_N,
	output logic O_WAKE_REQ,
	output logic O_TX_SPACE_N,
	output logic O_TX_SPACE_N_OE,
	input wire logic I_USB_CONFIGURED,
	input wire logic I_USB_SUSPEND,
	input wire logic I_HOST_WAKE_EN,
	input wire logic [7:0] I_FLUSH_MS,
	output logic O_POWER_ENABLE_N,
	input wire upf_pkg::upf_byte_t I_RX_USB,
	output logic O_RX_USB_READY,
	output upf_pkg::upf_byte_t O_TX_USB,
	input wire logic I_TX_USB_READY
);
	localparam int MSW = $clog2(upf_pkg::MS_CYCLES);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] rd_s1_q, rd_s2_q, wr_s1_q, wr_s2_q, wk_s1_q, wk_s2_q;
	logic rd_prev_q, wr_prev_q, wk_prev_q;
	logic [7:0] dat_s1_q, dat_s2_q;
	logic rd_n, wr, wk;
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rd_s1_q <= 3'h7;
			rd_s2_q <= 3'h7;
			wr_s1_q <= 3'h0;
			wr_s2_q <= 3'h0;
			wk_s1_q <= 3'h7;
			wk_s2_q <= 3'h7;
			dat_s1_q <= upf_pkg::BYTE_RST;
			dat_s2_q <= upf_pkg::BYTE_RST;
			rd_prev_q <= 1'b1;
			wr_prev_q <= 1'b0;
			wk_prev_q <= 1'b1;
		end else begin
			rd_s1_q <= {2'h0, I_READ_STROBE_N};
			rd_s2_q <= rd_s1_q;
			wr_s1_q <= {2'h0, I_WRITE_STROBE};
			wr_s2_q <= wr_s1_q;
			wk_s1_q <= {2'h0, I_RX_AVAIL_N};
			wk_s2_q <= wk_s1_q;
			dat_s1_q <= I_DATA;
			dat_s2_q <= dat_s1_q;
			rd_prev_q <= rd_n;
			wr_prev_q <= wr;
			wk_prev_q <= wk;
		end
	end
	assign rd_n = rd_s2_q[0];
	assign wr = wr_s2_q[0];
	assign wk = wk_s2_q[0];

	// ----------------------------------------
	// Buffers
	// ----------------------------------------
	upf_pkg::upf_byte_t rx_head, tx_in, tx_head;
	logic rx_pop, tx_ready, tx_pop;
	logic [8:0] rx_cnt;
	logic [7:0] tx_cnt;

	upf_fifo #(.DEPTH(upf_pkg::RX_DEPTH)) u_rx (
		.i_clk(I_CLK),
		.i_rst_b(I_RST_B),
		.i_wr(I_RX_USB),
		.o_wr_ready(O_RX_USB_READY),
		.o_rd(rx_head),
		.i_rd_ready(rx_pop),
		.o_count(rx_cnt)
	);

	// Strobe fall appends the sampled byte
	always_comb begin
		tx_in.valid = wr_prev_q && !wr;
		tx_in.data = dat_s2_q;
	end

	upf_fifo #(.DEPTH(upf_pkg::TX_DEPTH)) u_tx (
		.i_clk(I_CLK),
		.i_rst_b(I_RST_B),
		.i_wr(tx_in),
		.o_wr_ready(tx_ready),
		.o_rd(tx_head),
		.i_rd_ready(tx_pop),
		.o_count(tx_cnt)
	);

	// ----------------------------------------
	// Flush timer
	// ----------------------------------------
	// Held bytes leave when the timer expires or the buffer is full
	logic [MSW-1:0] tick_q, tick_d;
	logic [7:0] ms_q, ms_d, lim;
	logic flush_q, flush_d;
	always_comb begin
		lim = (I_FLUSH_MS < upf_pkg::FLUSH_MS_MIN) ?
			upf_pkg::FLUSH_MS_RST : I_FLUSH_MS;
		tick_d = tick_q;
		ms_d = ms_q;
		flush_d = flush_q;
		if (tx_cnt == 8'h00) begin
			tick_d = '0;
			ms_d = 8'h00;
			flush_d = 1'b0;
		end else if (!flush_q) begin
			// A full buffer cannot wait for the timer
			if (!tx_ready) begin
				flush_d = 1'b1;
			end
			if (tick_q == MSW'(upf_pkg::MS_CYCLES - 1)) begin
				tick_d = '0;
				ms_d = ms_q + 8'h01;
				// New count compared, so the send starts once the limit is reached
				if (ms_q + 8'h01 >= lim || !tx_ready) begin
					flush_d = 1'b1;
				end
			end else begin
				tick_d = tick_q + 1'b1;
			end
		end
		tx_pop = flush_q && I_TX_USB_READY && tx_head.valid;
	end
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			tick_q <= '0;
			ms_q <= 8'h00;
			flush_q <= 1'b0;
		end else begin
			tick_q <= tick_d;
			ms_q <= ms_d;
			flush_q <= flush_d;
		end
	end
	always_comb begin
		O_TX_USB.valid = flush_q && tx_head.valid;
		O_TX_USB.data = tx_head.data;
	end

	// ----------------------------------------
	// Pin outputs
	// ----------------------------------------
	upf_pkg::upf_bus_t bus_q, bus_d;
	logic rxf_q, rxf_d, rxf_oe_q, rxf_oe_d, txe_q, txe_d, txe_oe_q;
	logic txe_oe_d, pwr_q, pwr_d, wake_q, wake_d, suspend_in;
	always_comb begin
		suspend_in = I_HOST_WAKE_EN && pwr_q;
		rx_pop = rd_n && !rd_prev_q && rx_head.valid;
		bus_d.oe = !rd_n && rx_head.valid;
		bus_d.out = rx_head.data;
		// Byte hold during read: pop happens only on the rise
		rxf_d = !(rx_head.valid && !rx_pop);
		rxf_oe_d = !suspend_in;
		txe_d = !tx_ready;
		txe_oe_d = 1'b1;
		pwr_d = pwr_q;
		if (I_USB_SUSPEND) begin
			pwr_d = 1'b1;
		end else if (I_USB_CONFIGURED) begin
			pwr_d = 1'b0;
		end
		wake_d = suspend_in && wk_prev_q && !wk;
	end
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			bus_q <= '0;
			rxf_q <= 1'b1;
			rxf_oe_q <= 1'b0;
			txe_q <= 1'b1;
			txe_oe_q <= 1'b0;
			pwr_q <= 1'b1;
			wake_q <= 1'b0;
		end else begin
			bus_q <= bus_d;
			rxf_q <= rxf_d;
			rxf_oe_q <= rxf_oe_d;
			txe_q <= txe_d;
			txe_oe_q <= txe_oe_d;
			pwr_q <= pwr_d;
			wake_q <= wake_d;
		end
	end
	assign O_DATA = bus_q.out;
	assign O_DATA_OE = bus_q.oe;
	assign O_RX_AVAIL_N = rxf_q;
	assign O_RX_AVAIL_N_OE = rxf_oe_q;
	assign O_TX_SPACE_N = txe_q;
	assign O_TX_SPACE_N_OE = txe_oe_q;
	assign O_POWER_ENABLE_N = pwr_q;
	assign O_WAKE_REQ = wake_q;
endmodule // upf_port

// ### dv/upf_port_monitor.sv
// Checker for the parallel FIFO port pins
`timescale 1ns/1ps
module upf_port_monitor (
	input wire logic I_CLK,
	input wire logic I_RST_B,
	input wire logic I_READ_STROBE_N,
	input wire logic I_HOST_WAKE_EN,
	input wire logic I_USB_SUSPEND,
	input wire upf_pkg::upf_byte_t I_RX_USB,
	input wire logic O_RX_USB_READY,
	input wire logic [7:0] O_DATA,
	input wire logic O_DATA_OE,
	input wire logic O_RX_AVAIL_N,
	input wire logic O_RX_AVAIL_N_OE,
	input wire logic O_TX_SPACE_N_OE,
	input wire logic O_POWER_ENABLE_N,
	input wire logic O_WAKE_REQ,
	input wire upf_pkg::upf_byte_t O_TX_USB
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_B);
	AST_RD_OE: assert property ($fell(I_READ_STROBE_N) |-> ##[1:4] O_DATA_OE)
		else $error("bus not driven");
	AST_HOLD: assert property (O_DATA_OE && $past(O_DATA_OE) |-> $stable(O_DATA))
		else $error("read byte moved");
	AST_OE_CAUSE: assert property ($rose(O_DATA_OE) |-> $past(!I_READ_STROBE_N, 2))
		else $error("bus driven unasked");
	AST_RD_REL: assert property ($rose(I_READ_STROBE_N) |-> ##[1:4] !O_DATA_OE)
		else $error("bus not released");
	// Async reset: checked while reset is low, so no disable here
	AST_RST_FLAG: assert property (disable iff (1'b0) !I_RST_B |-> !O_TX_SPACE_N_OE && !O_RX_AVAIL_N_OE)
		else $error("flag driven in reset");
	AST_PWR: assert property (I_USB_SUSPEND [*2] |-> O_POWER_ENABLE_N)
		else $error("power enable low in suspend");
	AST_WAKE: assert property ((I_HOST_WAKE_EN && O_POWER_ENABLE_N) [*2] |-> !O_RX_AVAIL_N_OE)
		else $error("receive pin driven in wake mode");
	AST_RX_FLAG: assert property (I_RX_USB.valid && O_RX_USB_READY |-> ##[1:3] (!O_RX_AVAIL_N || !O_RX_AVAIL_N_OE))
		else $error("receive flag not low");
	cover property ($rose(O_DATA_OE));
	cover property (O_WAKE_REQ);
	cover property (O_TX_USB.valid);
endmodule // upf_port_monitor
bind upf_port upf_port_monitor u_upf_port_monitor (.*);

// ### dv/upf_ctrl_model.sv
// Controller model driving the FIFO strobes
`timescale 1ns/1ps
module upf_ctrl_model (
	input wire logic i_clk,
	input wire logic i_tx_space_n,
	output logic o_read_strobe_n,
	output logic o_write_strobe,
	output logic o_drive,
	output logic [7:0] o_data
);
	initial begin
		o_read_strobe_n = 1'b1;
		o_write_strobe = 1'b1;
		o_drive = 1'b1;
		o_data = 8'h5a;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge i_clk);
		#2;
	endtask
	task automatic wr(input logic [7:0] b);
		while (i_tx_space_n !== 1'b0) hold(1);
		o_data = b;
		o_write_strobe = 1'b1;
		hold(3);
		o_write_strobe = 1'b0;
		hold(3);
		o_data = ~b;
	endtask
	// Let go of the bus first, avoids a fight with the port
	task automatic rd(input int gap);
		o_drive = 1'b0;
		o_read_strobe_n = 1'b0;
		hold(5 + gap);
		o_read_strobe_n = 1'b1;
		hold(4);
		o_drive = 1'b1;
	endtask
endmodule // upf_ctrl_model

// ### dv/tb.sv
// Self-checking bench for the parallel FIFO port
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic cfg = 1'b0;
	logic susp = 1'b0;
	logic wk_en = 1'b0;
	logic pin = 1'b1;
	logic tx_en = 1'b0;
	logic tx_rdy = 1'b0;
	logic oe_q = 1'b0;
	logic [7:0] fl_ms = 8'h01;
	upf_pkg::upf_byte_t rxu = '0;
	upf_pkg::upf_byte_t txu;
	logic rd_n, wr, drv, oe, rxa, rxa_oe, txs, txs_oe, pwr_n, wake, rdy;
	logic [7:0] cd, dout;
	logic [7:0] rxq[$];
	logic [7:0] txq[$];
	int n_mismatch = 0;
	int cmp_count = 0;
	int n_wake = 0;
	wire [7:0] bus = oe ? dout : (drv ? cd : ~dout);
	wire rxa_pin = rxa_oe ? rxa : pin;
	always #25 clk = ~clk;
	upf_port u_upf_port (.I_CLK(clk), .I_RST_B(rst_b),
		.I_READ_STROBE_N(rd_n), .I_WRITE_STROBE(wr), .I_DATA(bus),
		.O_DATA(dout), .O_DATA_OE(oe), .O_RX_AVAIL_N(rxa),
		.O_RX_AVAIL_N_OE(rxa_oe), .I_RX_AVAIL_N(rxa_pin), .O_WAKE_REQ(wake),
		.O_TX_SPACE_N(txs), .O_TX_SPACE_N_OE(txs_oe), .I_USB_CONFIGURED(cfg),
		.I_USB_SUSPEND(susp), .I_HOST_WAKE_EN(wk_en), .I_FLUSH_MS(fl_ms),
		.O_POWER_ENABLE_N(pwr_n), .I_RX_USB(rxu), .O_RX_USB_READY(rdy),
		.O_TX_USB(txu), .I_TX_USB_READY(tx_rdy));
	upf_ctrl_model u_upf_ctrl_model (.i_clk(clk), .i_tx_space_n(txs),
		.o_read_strobe_n(rd_n), .o_write_strobe(wr), .o_drive(drv),
		.o_data(cd));
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic test_done();
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic send_rx(input logic [7:0] b);
		rxu = {1'b1, b};
		do @(posedge clk); while (rdy !== 1'b1);
		rxq.push_back(b);
		#2 rxu.valid = 1'b0;
	endtask
	task automatic send_tx(input int n);
		logic [7:0] b;
		repeat (n) begin
			b = 8'($urandom);
			txq.push_back(b);
			u_upf_ctrl_model.wr(b);
		end
	endtask
	always @(posedge clk) begin
		if (oe && !oe_q) cmp(dout, rxq.pop_front());
		if (txu.valid && tx_rdy) cmp(txu.data, txq.pop_front());
		if (wake) n_wake++;
		oe_q <= oe;
		#2 tx_rdy <= tx_en & 1'($urandom);
	end
	initial begin
		void'($urandom(32'hf065));
		repeat (12) @(posedge clk);
		cmp({7'h0, txs_oe | rxa_oe}, 8'h00);
		#2 rst_b = 1'b1;
		cfg = 1'b1;
		u_upf_ctrl_model.hold(4);
		cmp({7'h0, txs}, 8'h00);
		cmp({7'h0, pwr_n}, 8'h00);
		repeat (3) send_rx(8'($urandom));
		u_upf_ctrl_model.hold(4);
		cmp({7'h0, rxa}, 8'h00);
		repeat (3) u_upf_ctrl_model.rd($urandom_range(2));
		cmp({7'h0, rxa}, 8'h01);
		tx_en = 1'b1;
		send_tx(3);
		repeat (20100) @(posedge clk);
		cmp(8'(txq.size()), 8'h00);
		tx_en = 1'b0;
		fl_ms = 8'($urandom_range(255, 2));
		send_tx(128);
		u_upf_ctrl_model.hold(3);
		cmp({7'h0, txs}, 8'h01);
		tx_en = 1'b1;
		u_upf_ctrl_model.hold(600);
		cmp(8'(txq.size()), 8'h00);
		susp = 1'b1;
		wk_en = 1'b1;
		u_upf_ctrl_model.hold(3);
		pin = 1'b0;
		u_upf_ctrl_model.hold(6);
		cmp(8'(n_wake), 8'h01);
		test_done();
	end
	// Whole run is near 1.1 ms; nearly three times that means a hang
	initial begin
		#3000000;
		n_mismatch++;
		test_done();
	end
endmodule // tb
